// ---- rtl/ldcr_pkg.sv ----
// Constants and state type for the logical device configuration banks
package ldcr_pkg;
	// ==========================================================
	// Bus address fields (word address = {device, index})
	localparam int ADDR_W = 11;
	localparam logic [2:0] DEV_PAR = 3'h1;
	localparam logic [2:0] DEV_SER2 = 3'h2;
	localparam logic [2:0] DEV_SER1 = 3'h3;
	localparam logic [2:0] DEV_PWR = 3'h4;
	// ==========================================================
	// Register indexes
	localparam logic [7:0] IDX_ACT = 8'h30;
	localparam logic [7:0] IDX_RANGE = 8'h31;
	localparam logic [7:0] IDX_BASE_HI = 8'h60;
	localparam logic [7:0] IDX_BASE_LO = 8'h61;
	localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
	localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
	localparam logic [7:0] IDX_DMA_A = 8'h74;
	localparam logic [7:0] IDX_DMA_B = 8'h75;
	localparam logic [7:0] IDX_DEV_CFG = 8'hF0;
	localparam logic [7:0] IDX_FUNCTION_ENABLE_REG_ONE = 8'h20;
	// ==========================================================
	// Field masks and positions
	localparam logic [7:0] BASE_HI_MASK = 8'h07;
	localparam logic [7:0] SER_BASE_LO_MASK = 8'hF8;
	localparam logic [7:0] PWR_BASE_LO_MASK = 8'hFE;
	localparam int ACT_BIT = 0;
	localparam int ITYPE_WR_BIT = 1;
	localparam int FER_SER2_BIT = 2;
	localparam int FER_SER1_BIT = 3;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_NO_DMA = 8'h04;
	localparam logic [7:0] RST_PAR_IRQ = 8'h07;
	localparam logic [7:0] RST_SER2_BASE_HI = 8'h02;
	localparam logic [7:0] RST_SER1_BASE_HI = 8'h03;
	localparam logic [7:0] RST_SER_BASE_LO = 8'hF8;
	localparam logic [7:0] RST_SER2_IRQ = 8'h03;
	localparam logic [7:0] RST_SER1_IRQ = 8'h04;
	localparam logic RST_SER_ITYPE_B1 = 1'b1;
	localparam logic SER_ITYPE_B0 = 1'b1;
	localparam logic RST_PAR_ITYPE_B1 = 1'b0;
	localparam logic [7:0] RST_FUNCTION_ENABLE_REG_ONE = 8'h00;
	localparam logic [7:0] RST_DEV_CFG = 8'h00;
	// ==========================================================
	// Complete block state
	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
		logic [7:0] par_irq;
		logic par_it1;
		logic [7:0] par_dma;
		logic [7:0] par_cfg;
		logic [7:0] s2_act;
		logic [7:0] s2_rng;
		logic [7:0] s2_bh;
		logic [7:0] s2_bl;
		logic [7:0] s2_irq;
		logic s2_it1;
		logic [7:0] s2_rx;
		logic [7:0] s2_tx;
		logic [7:0] s2_cfg;
		logic [7:0] s1_act;
		logic [7:0] s1_rng;
		logic [7:0] s1_bh;
		logic [7:0] s1_bl;
		logic [7:0] s1_irq;
		logic s1_it1;
		logic [7:0] s1_cfg;
		logic [7:0] p_act;
		logic [7:0] p_rng;
		logic [7:0] p_bh;
		logic [7:0] p_bl;
		logic [7:0] p_fer;
	} ldcr_state_t;
endpackage

// ---- rtl/ldcr_top.sv ----
// Logical device configuration register banks on an Avalon-MM slave
// ==========================================================
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
module ldcr_top #(
	parameter logic [7:0] PAR_CFG_INIT = ldcr_pkg::RST_DEV_CFG,
	parameter logic [7:0] SER2_CFG_INIT = ldcr_pkg::RST_DEV_CFG,
	parameter logic [7:0] SER1_CFG_INIT = ldcr_pkg::RST_DEV_CFG
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic cfg_soft_reset,
	input wire logic par_extended_mode,
	input wire logic [ldcr_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [7:0] par_irq_select,
	output logic par_irq_type_sel,
	output logic [7:0] par_dma_select,
	output logic [7:0] par_device_config,
	output logic ser2_active,
	output logic [10:0] ser2_base,
	output logic [7:0] ser2_irq_select,
	output logic [7:0] ser2_rx_dma_select,
	output logic [7:0] ser2_tx_dma_select,
	output logic [7:0] ser2_device_config,
	output logic ser1_active,
	output logic [10:0] ser1_base,
	output logic [7:0] ser1_irq_select,
	output logic [7:0] ser1_device_config,
	output logic pwr_active,
	output logic [10:0] pwr_base
);
	// ==========================================================
	// Reset values
	function automatic ldcr_pkg::ldcr_state_t soft_vals(
		input ldcr_pkg::ldcr_state_t st
	);
		ldcr_pkg::ldcr_state_t r;
		r = st;
		r.par_irq = ldcr_pkg::RST_PAR_IRQ;
		r.par_it1 = ldcr_pkg::RST_PAR_ITYPE_B1;
		r.par_dma = ldcr_pkg::RST_NO_DMA;
		r.s2_act = ldcr_pkg::RST_ZERO;
		r.s2_rng = ldcr_pkg::RST_ZERO;
		r.s2_bh = ldcr_pkg::RST_SER2_BASE_HI;
		r.s2_bl = ldcr_pkg::RST_SER_BASE_LO;
		r.s2_irq = ldcr_pkg::RST_SER2_IRQ;
		r.s2_it1 = ldcr_pkg::RST_SER_ITYPE_B1;
		r.s2_rx = ldcr_pkg::RST_NO_DMA;
		r.s2_tx = ldcr_pkg::RST_NO_DMA;
		r.s1_act = ldcr_pkg::RST_ZERO;
		r.s1_rng = ldcr_pkg::RST_ZERO;
		r.s1_bh = ldcr_pkg::RST_SER1_BASE_HI;
		r.s1_bl = ldcr_pkg::RST_SER_BASE_LO;
		r.s1_irq = ldcr_pkg::RST_SER1_IRQ;
		r.s1_it1 = ldcr_pkg::RST_SER_ITYPE_B1;
		r.p_act = ldcr_pkg::RST_ZERO;
		r.p_rng = ldcr_pkg::RST_ZERO;
		r.p_bh = ldcr_pkg::RST_ZERO;
		r.p_bl = ldcr_pkg::RST_ZERO;
		return r;
	endfunction

	function automatic ldcr_pkg::ldcr_state_t hard_vals();
		ldcr_pkg::ldcr_state_t r;
		r = '0;
		r.par_cfg = PAR_CFG_INIT;
		r.s2_cfg = SER2_CFG_INIT;
		r.s1_cfg = SER1_CFG_INIT;
		r.p_fer = ldcr_pkg::RST_FUNCTION_ENABLE_REG_ONE;
		return soft_vals(r);
	endfunction

	localparam ldcr_pkg::ldcr_state_t HARD_STATE = hard_vals();

	// ==========================================================
	// Read decode
	function automatic logic [7:0] rd_val(
		input ldcr_pkg::ldcr_state_t st,
		input logic [2:0] dev,
		input logic [7:0] idx,
		input logic ext
	);
		logic [7:0] v;
		v = ldcr_pkg::RST_ZERO;
		case (dev)
		ldcr_pkg::DEV_PAR: begin
			case (idx)
			ldcr_pkg::IDX_IRQ_SEL: v = st.par_irq;
			ldcr_pkg::IDX_IRQ_TYPE: v = {6'h00, st.par_it1, ext};
			ldcr_pkg::IDX_DMA_A: v = st.par_dma;
			ldcr_pkg::IDX_DMA_B: v = ldcr_pkg::RST_NO_DMA;
			ldcr_pkg::IDX_DEV_CFG: v = st.par_cfg;
			default: v = ldcr_pkg::RST_ZERO;
			endcase
		end
		ldcr_pkg::DEV_SER2: begin
			case (idx)
			ldcr_pkg::IDX_ACT: v = st.s2_act;
			ldcr_pkg::IDX_RANGE: v = st.s2_rng;
			ldcr_pkg::IDX_BASE_HI: v = st.s2_bh;
			ldcr_pkg::IDX_BASE_LO: v = st.s2_bl;
			ldcr_pkg::IDX_IRQ_SEL: v = st.s2_irq;
			ldcr_pkg::IDX_IRQ_TYPE:
				v = {6'h00, st.s2_it1, ldcr_pkg::SER_ITYPE_B0};
			ldcr_pkg::IDX_DMA_A: v = st.s2_rx;
			ldcr_pkg::IDX_DMA_B: v = st.s2_tx;
			ldcr_pkg::IDX_DEV_CFG: v = st.s2_cfg;
			default: v = ldcr_pkg::RST_ZERO;
			endcase
		end
		ldcr_pkg::DEV_SER1: begin
			case (idx)
			ldcr_pkg::IDX_ACT: v = st.s1_act;
			ldcr_pkg::IDX_RANGE: v = st.s1_rng;
			ldcr_pkg::IDX_BASE_HI: v = st.s1_bh;
			ldcr_pkg::IDX_BASE_LO: v = st.s1_bl;
			ldcr_pkg::IDX_IRQ_SEL: v = st.s1_irq;
			ldcr_pkg::IDX_IRQ_TYPE:
				v = {6'h00, st.s1_it1, ldcr_pkg::SER_ITYPE_B0};
			ldcr_pkg::IDX_DMA_A: v = ldcr_pkg::RST_NO_DMA;
			ldcr_pkg::IDX_DMA_B: v = ldcr_pkg::RST_NO_DMA;
			ldcr_pkg::IDX_DEV_CFG: v = st.s1_cfg;
			default: v = ldcr_pkg::RST_ZERO;
			endcase
		end
		ldcr_pkg::DEV_PWR: begin
			if (idx == ldcr_pkg::IDX_ACT) begin
				v = st.p_act;
			end else if (st.p_act[ldcr_pkg::ACT_BIT]) begin
				case (idx)
				ldcr_pkg::IDX_RANGE: v = st.p_rng;
				ldcr_pkg::IDX_BASE_HI: v = st.p_bh;
				ldcr_pkg::IDX_BASE_LO: v = st.p_bl;
				ldcr_pkg::IDX_DMA_A: v = ldcr_pkg::RST_NO_DMA;
				ldcr_pkg::IDX_DMA_B: v = ldcr_pkg::RST_NO_DMA;
				ldcr_pkg::IDX_FUNCTION_ENABLE_REG_ONE: v = st.p_fer;
				default: v = ldcr_pkg::RST_ZERO;
				endcase
			end
		end
		default: v = ldcr_pkg::RST_ZERO;
		endcase
		return v;
	endfunction

	// ==========================================================
	// State
	ldcr_pkg::ldcr_state_t s_reg;
	ldcr_pkg::ldcr_state_t s_next;
	logic req;
	logic wr_go;
	logic [2:0] dev;
	logic [7:0] idx;
	logic [7:0] wd;
	logic pwr_open;

	assign req = avs_read | avs_write;
	assign dev = avs_address[10:8];
	assign idx = avs_address[7:0];
	assign wd = avs_writedata[7:0];
	assign wr_go = avs_write & ~s_reg.ack & avs_byteenable[0];
	assign pwr_open = s_reg.p_act[ldcr_pkg::ACT_BIT];

	always_comb begin
		s_next = s_reg;
		s_next.ack = req & ~s_reg.ack;
		if (avs_read & ~s_reg.ack) begin
			s_next.rdata = rd_val(s_reg, dev, idx, par_extended_mode);
		end
		if (wr_go) begin
			case (dev)
			ldcr_pkg::DEV_PAR: begin
				case (idx)
				ldcr_pkg::IDX_IRQ_SEL: s_next.par_irq = wd;
				ldcr_pkg::IDX_IRQ_TYPE:
					s_next.par_it1 = wd[ldcr_pkg::ITYPE_WR_BIT];
				ldcr_pkg::IDX_DMA_A: s_next.par_dma = wd;
				ldcr_pkg::IDX_DEV_CFG: s_next.par_cfg = wd;
				default: s_next.par_cfg = s_reg.par_cfg;
				endcase
			end
			ldcr_pkg::DEV_SER2: begin
				case (idx)
				ldcr_pkg::IDX_ACT: s_next.s2_act = wd;
				ldcr_pkg::IDX_RANGE: s_next.s2_rng = wd;
				ldcr_pkg::IDX_BASE_HI:
					s_next.s2_bh = wd & ldcr_pkg::BASE_HI_MASK;
				ldcr_pkg::IDX_BASE_LO:
					s_next.s2_bl = wd & ldcr_pkg::SER_BASE_LO_MASK;
				ldcr_pkg::IDX_IRQ_SEL: s_next.s2_irq = wd;
				ldcr_pkg::IDX_IRQ_TYPE:
					s_next.s2_it1 = wd[ldcr_pkg::ITYPE_WR_BIT];
				ldcr_pkg::IDX_DMA_A: s_next.s2_rx = wd;
				ldcr_pkg::IDX_DMA_B: s_next.s2_tx = wd;
				ldcr_pkg::IDX_DEV_CFG: s_next.s2_cfg = wd;
				default: s_next.s2_cfg = s_reg.s2_cfg;
				endcase
			end
			ldcr_pkg::DEV_SER1: begin
				case (idx)
				ldcr_pkg::IDX_ACT: s_next.s1_act = wd;
				ldcr_pkg::IDX_RANGE: s_next.s1_rng = wd;
				ldcr_pkg::IDX_BASE_HI:
					s_next.s1_bh = wd & ldcr_pkg::BASE_HI_MASK;
				ldcr_pkg::IDX_BASE_LO:
					s_next.s1_bl = wd & ldcr_pkg::SER_BASE_LO_MASK;
				ldcr_pkg::IDX_IRQ_SEL: s_next.s1_irq = wd;
				ldcr_pkg::IDX_IRQ_TYPE:
					s_next.s1_it1 = wd[ldcr_pkg::ITYPE_WR_BIT];
				ldcr_pkg::IDX_DEV_CFG: s_next.s1_cfg = wd;
				default: s_next.s1_cfg = s_reg.s1_cfg;
				endcase
			end
			ldcr_pkg::DEV_PWR: begin
				if (idx == ldcr_pkg::IDX_ACT) begin
					s_next.p_act = wd;
				end else if (pwr_open) begin
					case (idx)
					ldcr_pkg::IDX_RANGE: s_next.p_rng = wd;
					ldcr_pkg::IDX_BASE_HI:
						s_next.p_bh = wd & ldcr_pkg::BASE_HI_MASK;
					ldcr_pkg::IDX_BASE_LO:
						s_next.p_bl = wd & ldcr_pkg::PWR_BASE_LO_MASK;
					ldcr_pkg::IDX_FUNCTION_ENABLE_REG_ONE: s_next.p_fer = wd;
					default: s_next.p_fer = s_reg.p_fer;
					endcase
				end
			end
			default: s_next.p_fer = s_reg.p_fer;
			endcase
		end
		if (cfg_soft_reset) begin
			s_next = soft_vals(s_next);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s_reg <= HARD_STATE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Outputs
	assign avs_waitrequest = req & ~s_reg.ack;
	assign avs_readdata = {24'h000000, s_reg.rdata};
	assign par_irq_select = s_reg.par_irq;
	assign par_irq_type_sel = s_reg.par_it1;
	assign par_dma_select = s_reg.par_dma;
	assign par_device_config = s_reg.par_cfg;
	assign ser2_active = s_reg.s2_act[ldcr_pkg::ACT_BIT]
		& s_reg.p_fer[ldcr_pkg::FER_SER2_BIT];
	assign ser2_base = {s_reg.s2_bh[2:0], s_reg.s2_bl};
	assign ser2_irq_select = s_reg.s2_irq;
	assign ser2_rx_dma_select = s_reg.s2_rx;
	assign ser2_tx_dma_select = s_reg.s2_tx;
	assign ser2_device_config = s_reg.s2_cfg;
	assign ser1_active = s_reg.s1_act[ldcr_pkg::ACT_BIT]
		& s_reg.p_fer[ldcr_pkg::FER_SER1_BIT];
	assign ser1_base = {s_reg.s1_bh[2:0], s_reg.s1_bl};
	assign ser1_irq_select = s_reg.s1_irq;
	assign ser1_device_config = s_reg.s1_cfg;
	assign pwr_active = pwr_open;
	assign pwr_base = {s_reg.p_bh[2:0], s_reg.p_bl};

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_par_type_b0;
		s_reg.ack && avs_read && dev == ldcr_pkg::DEV_PAR
			&& idx == ldcr_pkg::IDX_IRQ_TYPE
			|-> avs_readdata[0] == $past(par_extended_mode);
	endproperty
	a_par_type_b0: assert property (p_par_type_b0)
		else $error("par irq type bit 0 wrong");

	property p_par_type_hi;
		s_reg.ack && avs_read && dev == ldcr_pkg::DEV_PAR
			&& idx == ldcr_pkg::IDX_IRQ_TYPE |-> avs_readdata[7:2] == 6'h00;
	endproperty
	a_par_type_hi: assert property (p_par_type_hi)
		else $error("par irq type high bits not zero");

	property p_cfg_keep;
		cfg_soft_reset |=> $stable(par_device_config)
			&& $stable(ser1_device_config);
	endproperty
	a_cfg_keep: assert property (p_cfg_keep)
		else $error("device config changed by soft reset");

	property p_ser2_soft;
		cfg_soft_reset |=> ser2_base == 11'h2F8 && ser2_rx_dma_select == 8'h04
			&& ser2_tx_dma_select == 8'h04 && ser2_irq_select == 8'h03;
	endproperty
	a_ser2_soft: assert property (p_ser2_soft)
		else $error("serial two soft reset values wrong");

	property p_ser1_soft;
		cfg_soft_reset |=> ser1_base == 11'h3F8 && ser1_irq_select == 8'h04
			&& !ser1_active && !ser2_active;
	endproperty
	a_ser1_soft: assert property (p_ser1_soft)
		else $error("serial one soft reset values wrong");

	property p_ser1_dma;
		s_reg.ack && avs_read && dev == ldcr_pkg::DEV_SER1
			&& (idx == ldcr_pkg::IDX_DMA_A || idx == ldcr_pkg::IDX_DMA_B)
			|-> avs_readdata == 32'h00000004;
	endproperty
	a_ser1_dma: assert property (p_ser1_dma)
		else $error("serial one DMA report not 04h");

	property p_pwr_lock;
		!pwr_active && !cfg_soft_reset |=> $stable(pwr_base);
	endproperty
	a_pwr_lock: assert property (p_pwr_lock)
		else $error("power base changed while inactive");

	property p_base_zero;
		ser2_base[2:0] == 3'h0 && ser1_base[2:0] == 3'h0 && !pwr_base[0];
	endproperty
	a_base_zero: assert property (p_base_zero)
		else $error("base low bits not zero");

	property p_base_hi;
		s_reg.ack && avs_read && idx == ldcr_pkg::IDX_BASE_HI
			|-> avs_readdata[7:3] == 5'h00;
	endproperty
	a_base_hi: assert property (p_base_hi)
		else $error("base high bits 7..3 not zero");

	property p_ser2_cfg;
		cfg_soft_reset && !avs_write |=> $stable(ser2_device_config);
	endproperty
	a_ser2_cfg: assert property (p_ser2_cfg)
		else $error("serial two config lost on soft reset");

	property p_ser2_rx_wr;
		wr_go && !cfg_soft_reset && dev == ldcr_pkg::DEV_SER2
			&& idx == ldcr_pkg::IDX_DMA_A
			|=> ser2_rx_dma_select == $past(wd);
	endproperty
	a_ser2_rx_wr: assert property (p_ser2_rx_wr)
		else $error("serial two rx DMA select not written");

	property p_ser2_irq_wr;
		wr_go && !cfg_soft_reset && dev == ldcr_pkg::DEV_SER2
			&& idx == ldcr_pkg::IDX_IRQ_SEL
			|=> ser2_irq_select == $past(wd);
	endproperty
	a_ser2_irq_wr: assert property (p_ser2_irq_wr)
		else $error("serial two irq select not written");
endmodule

// ---- sim/ldcr_host_model.sv ----
// Avalon-MM host model that reaches the configuration registers
`timescale 1ns/1ps
module ldcr_host_model (
	input wire logic sys_clk,
	output logic [10:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	initial begin
		avs_address = 11'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h0;
	end
	// ==========================================================
	// One transfer, held until waitrequest low
	task automatic xfer(input logic w, input logic [10:0] a,
		input logic [7:0] d, input logic [3:0] be,
		output logic [31:0] q);
		@(posedge sys_clk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge sys_clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_address <= ~a;
		avs_writedata <= ~{24'h000000, d};
		avs_byteenable <= ~be;
	endtask
endmodule

// ---- sim/ldcr_top_tb.sv ----
// Self-checking bench for the configuration register banks
`timescale 1ns/1ps
module ldcr_top_tb;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic cfg_soft_reset = 1'b0;
	logic par_extended_mode = 1'b0;
	logic [10:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic par_irq_type_sel;
	logic ser2_active;
	logic ser1_active;
	logic [10:0] ser2_base;
	logic [10:0] pwr_base;
	logic [7:0] par_irq_select;
	logic [7:0] par_dma_select;
	logic [7:0] par_device_config;
	logic [7:0] ser2_irq_select;
	logic [7:0] ser2_rx_dma_select;
	logic [7:0] ser2_tx_dma_select;
	logic [7:0] ser2_device_config;
	logic [10:0] ser1_base;
	logic [7:0] ser1_irq_select;
	logic [7:0] ser1_device_config;
	logic pwr_active;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	// Reset values {device, index, value}
	localparam logic [19:0] RST_TAB [21] = '{20'h17007, 20'h17100,
		20'h17404, 20'h17504, 20'h1F000, 20'h23000, 20'h23100,
		20'h26002, 20'h261F8, 20'h27003, 20'h27103, 20'h27404,
		20'h27504, 20'h2F000, 20'h33000, 20'h33100, 20'h36003,
		20'h361F8, 20'h37004, 20'h37103, 20'h3F000};
	// Write masks {device, index, after FFh, after 00h}
	localparam logic [27:0] MSK_TAB [23] = '{28'h170FF00,
		28'h1710200, 28'h174FF00, 28'h1750404, 28'h1F0FF00,
		28'h230FF00, 28'h231FF00, 28'h2600700, 28'h261F800,
		28'h270FF00, 28'h2710301, 28'h274FF00, 28'h275FF00,
		28'h2F0FF00, 28'h330FF00, 28'h331FF00, 28'h3600700,
		28'h361F800, 28'h370FF00, 28'h3710301, 28'h3740404,
		28'h3750404, 28'h3F0FF00};
	always #4 sys_clk = ~sys_clk;
	ldcr_host_model ldcr_host_model_inst (.sys_clk(sys_clk),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	ldcr_top ldcr_top_inst (.sys_clk(sys_clk), .reset(reset),
		.cfg_soft_reset(cfg_soft_reset),
		.par_extended_mode(par_extended_mode),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.par_irq_select(par_irq_select),
		.par_irq_type_sel(par_irq_type_sel),
		.par_dma_select(par_dma_select),
		.par_device_config(par_device_config),
		.ser2_active(ser2_active),
		.ser2_base(ser2_base), .ser2_irq_select(ser2_irq_select),
		.ser2_rx_dma_select(ser2_rx_dma_select),
		.ser2_tx_dma_select(ser2_tx_dma_select),
		.ser2_device_config(ser2_device_config),
		.ser1_active(ser1_active),
		.ser1_base(ser1_base), .ser1_irq_select(ser1_irq_select),
		.ser1_device_config(ser1_device_config),
		.pwr_active(pwr_active), .pwr_base(pwr_base));
	// ==========================================================
	// Shared helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] d, input logic [7:0] i,
		input logic [7:0] v);
		logic [31:0] q;
		ldcr_host_model_inst.xfer(1'b1, {d, i}, v, 4'hF, q);
	endtask
	task automatic rd(input logic [2:0] d, input logic [7:0] i,
		input logic [7:0] e);
		logic [31:0] q;
		ldcr_host_model_inst.xfer(1'b0, {d, i}, 8'h00, 4'hF, q);
		chk(q, {24'h000000, e});
	endtask
	task automatic summarize;
		if (bad_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset_vals;
		foreach (RST_TAB[i])
			rd(RST_TAB[i][18:16], RST_TAB[i][15:8], RST_TAB[i][7:0]);
		rd(3'h4, 8'h30, 8'h00);
		rd(3'h4, 8'h60, 8'h00);
	endtask
	task automatic t_masks;
		logic [31:0] q;
		foreach (MSK_TAB[i]) begin
			wr(MSK_TAB[i][26:24], MSK_TAB[i][23:16], 8'hFF);
			rd(MSK_TAB[i][26:24], MSK_TAB[i][23:16], MSK_TAB[i][15:8]);
			wr(MSK_TAB[i][26:24], MSK_TAB[i][23:16], 8'h00);
			rd(MSK_TAB[i][26:24], MSK_TAB[i][23:16], MSK_TAB[i][7:0]);
		end
		wr(3'h2, 8'h60, 8'hFF);
		wr(3'h2, 8'h61, 8'hFF);
		chk({21'h000000, ser2_base}, 32'h000007F8);
		ldcr_host_model_inst.xfer(1'b1, 11'h270, 8'h55, 4'hE, q);
		rd(3'h2, 8'h70, 8'h00);
		rd(3'h0, 8'h30, 8'h00);
		wr(3'h5, 8'h30, 8'hFF);
		rd(3'h5, 8'h30, 8'h00);
	endtask
	task automatic t_par_ext;
		par_extended_mode <= 1'b1;
		rd(3'h1, 8'h71, 8'h01);
		wr(3'h1, 8'h71, 8'hFF);
		rd(3'h1, 8'h71, 8'h03);
		chk({31'h0, par_irq_type_sel}, 32'h1);
		par_extended_mode <= 1'b0;
		rd(3'h1, 8'h71, 8'h02);
	endtask
	task automatic t_pwr;
		wr(3'h4, 8'h61, 8'hFF);
		wr(3'h4, 8'h30, 8'h01);
		rd(3'h4, 8'h61, 8'h00);
		wr(3'h4, 8'h60, 8'hFF);
		wr(3'h4, 8'h61, 8'hFF);
		rd(3'h4, 8'h60, 8'h07);
		rd(3'h4, 8'h61, 8'hFE);
		rd(3'h4, 8'h74, 8'h04);
		rd(3'h4, 8'h75, 8'h04);
		chk({21'h000000, pwr_base}, 32'h000007FE);
		wr(3'h4, 8'h30, 8'h00);
		rd(3'h4, 8'h61, 8'h00);
		wr(3'h4, 8'h61, 8'h00);
		wr(3'h4, 8'h30, 8'h01);
		rd(3'h4, 8'h61, 8'hFE);
	endtask
	task automatic t_enable;
		wr(3'h2, 8'h30, 8'h01);
		wr(3'h3, 8'h30, 8'h01);
		chk({30'h0, ser2_active, ser1_active}, 32'h0);
		wr(3'h4, 8'h20, 8'h04);
		chk({30'h0, ser2_active, ser1_active}, 32'h2);
		wr(3'h4, 8'h20, 8'h08);
		chk({30'h0, ser2_active, ser1_active}, 32'h1);
	endtask
	task automatic t_soft;
		logic [31:0] o;
		wr(3'h1, 8'hF0, 8'hA5);
		wr(3'h2, 8'hF0, 8'h5A);
		wr(3'h3, 8'hF0, 8'h3C);
		wr(3'h2, 8'h70, 8'h0B);
		@(posedge sys_clk);
		cfg_soft_reset <= 1'b1;
		@(posedge sys_clk);
		cfg_soft_reset <= 1'b0;
		rd(3'h1, 8'hF0, 8'hA5);
		rd(3'h2, 8'hF0, 8'h5A);
		rd(3'h3, 8'hF0, 8'h3C);
		rd(3'h2, 8'h70, 8'h03);
		rd(3'h3, 8'h61, 8'hF8);
		rd(3'h2, 8'h30, 8'h00);
		rd(3'h4, 8'h30, 8'h00);
		wr(3'h4, 8'h30, 8'h01);
		rd(3'h4, 8'h61, 8'h00);
		rd(3'h4, 8'h20, 8'h08);
		o = {par_irq_select, par_dma_select, par_device_config,
			ser2_irq_select};
		chk(o, 32'h0704A503);
		o = {ser2_rx_dma_select, ser2_tx_dma_select, ser2_device_config,
			ser1_irq_select};
		chk(o, 32'h04045A04);
		o = {5'h00, ser1_base, ser1_device_config, 7'h00, pwr_active};
		chk(o, 32'h03F83C01);
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		t_reset_vals;
	endtask
	// ==========================================================
	// Main sequence and timeout
	initial begin
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		t_reset_vals;
		t_masks;
		t_par_ext;
		t_pwr;
		t_enable;
		t_soft;
		summarize;
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			bad_count++;
			summarize;
		end
	end
endmodule
